// ==== rtl/rrm_pkg.sv ====
// Package holding the register map, field positions and reset values of the reader register bank
package rrm_pkg;
    // ------------------------------------------------------------
    // Address word layout
    // ------------------------------------------------------------
    localparam int AW_CMD_BIT = 7;
    localparam int AW_READ_BIT = 6;
    localparam int AW_CONT_BIT = 5;
    localparam int AW_ADDR_MSB = 4;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [4:0] ADR_CHIP_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADR_PROTOCOL_SELECT = 5'h01;
    localparam logic [4:0] ADR_SUBSET_FIRST = 5'h02;
    localparam logic [4:0] ADR_MOD_CLOCK_OUT = 5'h09;
    localparam logic [4:0] ADR_SUBSET_LAST = 5'h0b;
    localparam logic [4:0] ADR_INTERRUPT_STATUS = 5'h0c;
    localparam logic [4:0] ADR_COLL_POS_IRQ_MASK = 5'h0d;
    localparam logic [4:0] ADR_COLLISION_POSITION = 5'h0e;
    localparam logic [4:0] ADR_SIGNAL_LEVEL_OSC = 5'h0f;
    localparam logic [4:0] ADR_TEST_A = 5'h1a;
    localparam logic [4:0] ADR_TEST_B = 5'h1b;
    localparam logic [4:0] ADR_FIFO_STATUS = 5'h1c;
    localparam logic [4:0] ADR_TX_LENGTH_FIRST = 5'h1d;
    localparam logic [4:0] ADR_TX_LENGTH_SECOND = 5'h1e;
    localparam logic [4:0] ADR_FIFO_DATA_PORT = 5'h1f;
    // ------------------------------------------------------------
    // Chip status control fields and reset values
    // ------------------------------------------------------------
    localparam int CSC_LOW_POWER_HOLD = 7;
    localparam int CSC_BYPASS_FRAMING = 6;
    localparam int CSC_CARRIER_OUT = 5;
    localparam int CSC_TX_POWER_HALVE = 4;
    localparam int CSC_RX_INPUT_SEL = 3;
    localparam int CSC_FIELD_MEASURE = 1;
    localparam int CSC_SUPPLY_RANGE = 0;
    localparam logic [7:0] CSC_WRITE_MASK = 8'hfb;
    localparam logic [7:0] CSC_RESET = 8'h01;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int PSEL_DIRECT_VARIANT = 6;
    // ------------------------------------------------------------
    // Standby wake time
    // ------------------------------------------------------------
    localparam int WAKE_TIME_US = 100;
    localparam int CLK_MHZ = 200;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
endpackage

// ==== rtl/rrm_reg_bank.sv ====
// Register bank with chip status control decode of the reader front end
// What this block does
// - Chip status control loads 0x01 while chip enable is low or at power-on reset.
// - Low-power hold bit selects standby; active resumes about 100 us after clearing.
// - Bypass framing gives direct mode 0 or 1; cleared uses automatic framing.
// - Carrier output enable turns transmitter and receivers on; clear keeps transmitter off.
// - Transmit power halve selects half power driver; clear selects full power.
// - Receive input select routes aux input when set, main input when clear.
// - Field measure enable forces receiver and oscillator on; else receiver follows carrier.
// - Supply range select chooses 5 V when set, 3 V when clear.
// - Addresses 0x00 to 0x0B decode as host read/write registers.
// - Interrupt status, collision position and signal levels read only.
// - Address 0x0D is read/write collision bits with interrupt mask.
// - Modulator and system clock output control at 0x09 is read/write.
// - Address word bit7 command, bit6 read, bit5 continuous, bits4-0 address.
`timescale 1ns/100ps
`default_nettype none
module rrm_reg_bank (
    // Clock and resets
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic chip_enable_in,
    // Host byte port
    input wire logic host_valid_in,
    input wire logic [7:0] host_byte_in,
    input wire logic host_frame_in,
    output logic [7:0] host_rdata_out,
    output logic host_rvalid_out,
    output logic host_cmd_out,
    output logic [4:0] host_cmd_code_out,
    // Engine status inputs
    input wire logic [7:0] irq_status_in,
    input wire logic [7:0] coll_pos_in,
    input wire logic [7:0] signal_level_in,
    input wire logic [7:0] fifo_status_in,
    input wire logic [7:0] fifo_rdata_in,
    output logic fifo_wr_out,
    output logic fifo_rd_out,
    output logic [7:0] fifo_wdata_out,
    // Front-end controls
    input wire logic main_receive_input_in,
    input wire logic aux_receive_input_in,
    output logic receiver_input_out,
    output logic standby_out,
    output logic ready_out,
    output logic direct_mode_out,
    output logic direct_variant_out,
    output logic transmitter_on_out,
    output logic receiver_on_out,
    output logic oscillator_on_out,
    output logic transmit_power_halve_out,
    output logic supply_range_select_out,
    output logic [7:0] protocol_select_out,
    output logic [7:0] modulator_clock_out_control_out,
    output logic [7:0] irq_mask_out
);
    // ------------------------------------------------------------
    // Host framing state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        RRM_IDLE = 3'b001,
        RRM_WDATA = 3'b010,
        RRM_RDATA = 3'b100
    } rrm_state_t;

    rrm_state_t state_r;
    logic [4:0] addr_r;
    logic cont_r;
    logic [7:0] csc_r;
    logic [7:0] rw_r [0:31];
    logic [15:0] wake_cnt_r;
    logic word_take;
    logic is_cmd;
    logic wr_take;
    logic rd_take;
    logic [4:0] acc_addr;
    logic [7:0] rd_mux;

    // Reset of the bank: power-on reset or chip enable low
    logic bank_clear;
    assign bank_clear = !chip_enable_in;

    // Address word decode
    assign word_take = host_valid_in && host_frame_in;
    assign is_cmd = host_byte_in[rrm_pkg::AW_CMD_BIT];
    assign acc_addr = (state_r == RRM_IDLE) ? host_byte_in[rrm_pkg::AW_ADDR_MSB:0] : addr_r;
    assign wr_take = word_take && (state_r == RRM_WDATA);
    assign rd_take = word_take && (state_r == RRM_RDATA);

    // Sequencer: address word then data words; continuous mode bumps address
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r <= RRM_IDLE;
            addr_r <= 5'h00;
            cont_r <= 1'b0;
        end else if (!host_frame_in || bank_clear) begin
            state_r <= RRM_IDLE;
        end else if (host_valid_in) begin
            case (state_r)
                RRM_IDLE: begin
                    if (!is_cmd) begin
                        addr_r <= host_byte_in[rrm_pkg::AW_ADDR_MSB:0];
                        cont_r <= host_byte_in[rrm_pkg::AW_CONT_BIT];
                        state_r <= host_byte_in[rrm_pkg::AW_READ_BIT] ? RRM_RDATA : RRM_WDATA;
                    end
                end
                RRM_WDATA, RRM_RDATA: begin
                    if (cont_r) begin
                        addr_r <= addr_r + 5'd1;
                    end else begin
                        state_r <= RRM_IDLE;
                    end
                end
                default: state_r <= RRM_IDLE;
            endcase
        end
    end

    // Commands pass straight to the engines
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_cmd_out <= 1'b0;
            host_cmd_code_out <= 5'h00;
        end else begin
            host_cmd_out <= word_take && (state_r == RRM_IDLE) && is_cmd;
            if (word_take && (state_r == RRM_IDLE) && is_cmd) begin
                host_cmd_code_out <= host_byte_in[rrm_pkg::AW_ADDR_MSB:0];
            end
        end
    end

    // Chip status control; reserved bit never stored
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            csc_r <= rrm_pkg::CSC_RESET;
        end else if (bank_clear) begin
            csc_r <= rrm_pkg::CSC_RESET;
        end else if (wr_take && addr_r == rrm_pkg::ADR_CHIP_STATUS_CONTROL) begin
            csc_r <= host_byte_in & rrm_pkg::CSC_WRITE_MASK;
        end
    end

    // Plain read/write storage; read-only slots are not written
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < 32; i++) begin
                rw_r[i] <= rrm_pkg::REG_RESET;
            end
        end else if (bank_clear) begin
            for (int i = 0; i < 32; i++) begin
                rw_r[i] <= rrm_pkg::REG_RESET;
            end
        end else if (wr_take) begin
            if ((addr_r >= rrm_pkg::ADR_PROTOCOL_SELECT && addr_r <= rrm_pkg::ADR_SUBSET_LAST)
                || addr_r == rrm_pkg::ADR_COLL_POS_IRQ_MASK
                || (addr_r >= rrm_pkg::ADR_TEST_A && addr_r <= rrm_pkg::ADR_TX_LENGTH_SECOND
                    && addr_r != rrm_pkg::ADR_FIFO_STATUS)) begin
                rw_r[addr_r] <= host_byte_in;
            end
        end
    end

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = 8'h00;
        case (acc_addr)
            rrm_pkg::ADR_CHIP_STATUS_CONTROL: rd_mux = csc_r;
            rrm_pkg::ADR_INTERRUPT_STATUS: rd_mux = irq_status_in;
            rrm_pkg::ADR_COLLISION_POSITION: rd_mux = coll_pos_in;
            rrm_pkg::ADR_SIGNAL_LEVEL_OSC: rd_mux = signal_level_in;
            rrm_pkg::ADR_FIFO_STATUS: rd_mux = fifo_status_in;
            rrm_pkg::ADR_FIFO_DATA_PORT: rd_mux = fifo_rdata_in;
            default: begin
                if (acc_addr <= rrm_pkg::ADR_SUBSET_LAST || acc_addr == rrm_pkg::ADR_COLL_POS_IRQ_MASK
                    || (acc_addr >= rrm_pkg::ADR_TEST_A && acc_addr <= rrm_pkg::ADR_TX_LENGTH_SECOND)) begin
                    rd_mux = rw_r[acc_addr];
                end
            end
        endcase
    end

    // Read data registered one cycle after the data slot
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            host_rdata_out <= 8'h00;
            host_rvalid_out <= 1'b0;
        end else begin
            host_rvalid_out <= rd_take;
            if (rd_take) begin
                host_rdata_out <= rd_mux;
            end
        end
    end

    // FIFO port strobes
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            fifo_wr_out <= 1'b0;
            fifo_rd_out <= 1'b0;
            fifo_wdata_out <= 8'h00;
        end else begin
            fifo_wr_out <= wr_take && addr_r == rrm_pkg::ADR_FIFO_DATA_PORT;
            fifo_rd_out <= rd_take && addr_r == rrm_pkg::ADR_FIFO_DATA_PORT;
            if (wr_take) begin
                fifo_wdata_out <= host_byte_in;
            end
        end
    end

    // Standby wake timer: full operation returns after the wake time
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wake_cnt_r <= 16'h0000;
        end else if (csc_r[rrm_pkg::CSC_LOW_POWER_HOLD]) begin
            wake_cnt_r <= 16'(rrm_pkg::WAKE_CYCLES);
        end else if (wake_cnt_r != 16'h0000) begin
            wake_cnt_r <= wake_cnt_r - 16'd1;
        end
    end
    assign standby_out = csc_r[rrm_pkg::CSC_LOW_POWER_HOLD];
    assign ready_out = !standby_out && (wake_cnt_r == 16'h0000);

    // Front-end control decode
    // Direct variant comes from protocol select; host sets it first
    assign direct_mode_out = csc_r[rrm_pkg::CSC_BYPASS_FRAMING];
    assign direct_variant_out = rw_r[rrm_pkg::ADR_PROTOCOL_SELECT][rrm_pkg::PSEL_DIRECT_VARIANT];
    assign transmitter_on_out = csc_r[rrm_pkg::CSC_CARRIER_OUT];
    assign receiver_on_out = csc_r[rrm_pkg::CSC_CARRIER_OUT]
        || csc_r[rrm_pkg::CSC_FIELD_MEASURE];
    assign oscillator_on_out = csc_r[rrm_pkg::CSC_CARRIER_OUT]
        || csc_r[rrm_pkg::CSC_FIELD_MEASURE];
    assign transmit_power_halve_out = csc_r[rrm_pkg::CSC_TX_POWER_HALVE];
    assign receiver_input_out = csc_r[rrm_pkg::CSC_RX_INPUT_SEL]
        ? aux_receive_input_in : main_receive_input_in;
    assign supply_range_select_out = csc_r[rrm_pkg::CSC_SUPPLY_RANGE];
    assign protocol_select_out = rw_r[rrm_pkg::ADR_PROTOCOL_SELECT];
    assign modulator_clock_out_control_out = rw_r[rrm_pkg::ADR_MOD_CLOCK_OUT];
    assign irq_mask_out = rw_r[rrm_pkg::ADR_COLL_POS_IRQ_MASK];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_CLEAR_LOADS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !chip_enable_in |=> csc_r == rrm_pkg::CSC_RESET) else $error("csc not reset");
    AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (!nrst_in)
        csc_r[2] == 1'b0) else $error("reserved bit set");
    AST_CSC_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && chip_enable_in && addr_r == rrm_pkg::ADR_CHIP_STATUS_CONTROL
        |=> csc_r == ($past(host_byte_in) & 8'hfb)) else $error("csc write lost");
    AST_WAKE_DELAY: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(standby_out) |-> !ready_out [*8]) else $error("woke too early");
    AST_TX_FOLLOWS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        transmitter_on_out == csc_r[5] && (!transmitter_on_out || receiver_on_out))
        else $error("carrier decode wrong");
    AST_FIELD_MEASURE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        csc_r[1] |-> receiver_on_out && oscillator_on_out) else $error("rx not forced");
    AST_RX_ROUTE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        receiver_input_out == (csc_r[3] ? aux_receive_input_in : main_receive_input_in))
        else $error("rx route wrong");
    AST_RO_READ: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_take && addr_r == rrm_pkg::ADR_INTERRUPT_STATUS
        |=> host_rvalid_out && host_rdata_out == $past(irq_status_in))
        else $error("status read wrong");
    AST_CMD_DECODE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        word_take && state_r == RRM_IDLE && is_cmd |=> host_cmd_out && state_r == RRM_IDLE)
        else $error("command not decoded");
    AST_POWER_HALVE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        transmit_power_halve_out == csc_r[4] && supply_range_select_out == csc_r[0]
        && direct_mode_out == csc_r[6]) else $error("control decode wrong");

    // ------------------------------------------------------------
    // Sequencing and storage checks
    // ------------------------------------------------------------
    // Continuous mode steps the address once per data slot, wrapping at five bits
    AST_CONT_STEP: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_take || rd_take) && cont_r && chip_enable_in
        |=> addr_r == $past(addr_r) + 5'd1) else $error("address not stepped");
    // A single access ends after its one data slot
    AST_SINGLE_END: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_take || rd_take) && !cont_r
        |=> state_r == RRM_IDLE) else $error("single access not ended");
    // Frame low always aborts; a cut frame must not leave a half access pending
    AST_ABORT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !host_frame_in
        |=> state_r == RRM_IDLE) else $error("frame abort ignored");
    // Chip status control changes only by a host write or a bank clear
    AST_CSC_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
        chip_enable_in && !(wr_take && addr_r == rrm_pkg::ADR_CHIP_STATUS_CONTROL)
        |=> $stable(csc_r)) else $error("csc changed unasked");
    // Protocol select stores the written byte
    AST_PSEL_STORE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && chip_enable_in && addr_r == rrm_pkg::ADR_PROTOCOL_SELECT
        |=> protocol_select_out == $past(host_byte_in)) else $error("psel lost");
    // Modulator and clock output control stores the written byte
    AST_MOD_STORE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && chip_enable_in && addr_r == rrm_pkg::ADR_MOD_CLOCK_OUT
        |=> modulator_clock_out_control_out == $past(host_byte_in))
        else $error("modulator control lost");
    // Interrupt mask stores the written byte
    AST_MASK_STORE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && chip_enable_in && addr_r == rrm_pkg::ADR_COLL_POS_IRQ_MASK
        |=> irq_mask_out == $past(host_byte_in)) else $error("irq mask lost");
    // Test register stores the written byte
    AST_TEST_STORE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && chip_enable_in && addr_r == rrm_pkg::ADR_TEST_A
        |=> rw_r[rrm_pkg::ADR_TEST_A] == $past(host_byte_in)) else $error("test lost");
    // Data port writes go to the FIFO with their byte
    AST_FIFO_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wr_take && addr_r == rrm_pkg::ADR_FIFO_DATA_PORT
        |=> fifo_wr_out && fifo_wdata_out == $past(host_byte_in))
        else $error("fifo write lost");
    // Data port reads pop the FIFO once
    AST_FIFO_READ: assert property (@(posedge clk_in) disable iff (!nrst_in)
        rd_take && addr_r == rrm_pkg::ADR_FIFO_DATA_PORT
        |=> fifo_rd_out) else $error("fifo read lost");
    // No FIFO write strobe without a data port write
    AST_FIFO_QUIET: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(wr_take && addr_r == rrm_pkg::ADR_FIFO_DATA_PORT)
        |=> !fifo_wr_out) else $error("spurious fifo write");
    // Read valid only follows a data slot of a read
    AST_RVALID_ONLY: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !rd_take
        |=> !host_rvalid_out) else $error("spurious read valid");
    // Read data stands until the next read
    AST_RDATA_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !rd_take
        |=> $stable(host_rdata_out)) else $error("read data moved");
    // Direct variant mirrors the protocol select bit
    AST_VARIANT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        direct_variant_out == protocol_select_out[rrm_pkg::PSEL_DIRECT_VARIANT])
        else $error("direct variant wrong");
    // Standby never reports ready
    AST_STANDBY_HOLD: assert property (@(posedge clk_in) disable iff (!nrst_in)
        standby_out
        |-> !ready_out) else $error("ready in standby");
    // Ready comes as soon as the wake count runs out
    AST_READY_AFTER: assert property (@(posedge clk_in) disable iff (!nrst_in)
        wake_cnt_r == 16'h0001 && !standby_out
        |=> ready_out || standby_out) else $error("ready late");
    // Carrier off keeps the transmitter off
    AST_TX_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !csc_r[rrm_pkg::CSC_CARRIER_OUT]
        |-> !transmitter_on_out) else $error("transmitter on");
    // Neither carrier nor field measure leaves receiver and oscillator off
    AST_OSC_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !csc_r[rrm_pkg::CSC_CARRIER_OUT] && !csc_r[rrm_pkg::CSC_FIELD_MEASURE]
        |-> !receiver_on_out && !oscillator_on_out) else $error("receiver on");
endmodule // rrm_reg_bank
`default_nettype wire

// ==== bench/rrm_host_model.sv ====
// Host controller model driving the byte port of the register bank
`timescale 1ns/100ps
`default_nettype none
module rrm_host_model (
    // Clock
    input wire logic clk_in,
    // Answer from the bank
    input wire logic [7:0] host_rdata_in,
    input wire logic host_rvalid_in,
    // Byte port towards the bank
    output logic host_valid_out,
    output logic [7:0] host_byte_out,
    output logic host_frame_out
);
    int gap = 0;
    // Idle port at time zero
    initial begin
        host_valid_out = 1'b0;
        host_frame_out = 1'b0;
        host_byte_out = 8'h5a;
    end
    // One byte; idle slots first let a slow host be modelled
    task automatic send(input logic [7:0] b);
        repeat (gap) begin
            @(posedge clk_in);
            host_valid_out <= 1'b0;
            host_byte_out <= ~b;
        end
        @(posedge clk_in);
        host_frame_out <= 1'b1;
        host_valid_out <= 1'b1;
        host_byte_out <= b;
    endtask
    // End of frame; the byte lines never keep a stale value
    task automatic release_port();
        @(posedge clk_in);
        host_valid_out <= 1'b0;
        host_frame_out <= 1'b0;
        host_byte_out <= ~host_byte_out;
    endtask
    // Write of n bytes, continuous when n is above one
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input int n);
        send({2'b00, n > 1, a});
        for (int i = 0; i < n; i++) send(8'(d + i));
        release_port();
    endtask
    // Single read; the data slot carries a dummy byte
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        send({3'b010, a});
        send(8'h00);
        release_port();
        d = 8'hxx;
        repeat (4) begin
            @(posedge clk_in);
            if (host_rvalid_in === 1'b1) begin
                d = host_rdata_in;
                break;
            end
        end
    endtask
    // Command word
    task automatic cmd(input logic [4:0] c);
        send({3'b100, c});
        release_port();
    endtask
endmodule // rrm_host_model
`default_nettype wire

// ==== bench/reader_register_map_chip_control_tb.sv ====
// Self-checking testbench of the reader register bank
`timescale 1ns/100ps
`default_nettype none
module reader_register_map_chip_control_tb;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic chip_enable_in = 1'b1;
    logic main_rx = 1'b0;
    logic aux_rx = 1'b0;
    logic [7:0] irq_s = 8'h00, coll_s = 8'h00, lvl_s = 8'h00, fst_s = 8'h00, frd_s = 8'h00;
    wire logic hv, hf, rvalid, cmd_p, fwr, frd, rx_sel, stby, rdy, dmode, dvar;
    wire logic tx_on, rx_on, osc_on, half, vsel;
    wire logic [7:0] hb, rdata, fwd, psel, modc, imask;
    wire logic [4:0] cmd_c;
    logic [7:0] mdl [0:31];
    logic [4:0] last_cmd = 5'h00;
    logic [7:0] v;
    int num_errors = 0;
    int n_checks = 0;
    int n_fwr = 0;
    int n_frd = 0;
    integer seed = 32'hb502d68a;
    always #2.5 clk_in = ~clk_in;
    rrm_reg_bank u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .chip_enable_in(chip_enable_in),
        .host_valid_in(hv), .host_byte_in(hb), .host_frame_in(hf), .host_rdata_out(rdata),
        .host_rvalid_out(rvalid), .host_cmd_out(cmd_p), .host_cmd_code_out(cmd_c),
        .irq_status_in(irq_s), .coll_pos_in(coll_s), .signal_level_in(lvl_s),
        .fifo_status_in(fst_s), .fifo_rdata_in(frd_s), .fifo_wr_out(fwr), .fifo_rd_out(frd),
        .fifo_wdata_out(fwd), .main_receive_input_in(main_rx), .aux_receive_input_in(aux_rx),
        .receiver_input_out(rx_sel), .standby_out(stby), .ready_out(rdy),
        .direct_mode_out(dmode), .direct_variant_out(dvar), .transmitter_on_out(tx_on),
        .receiver_on_out(rx_on), .oscillator_on_out(osc_on), .transmit_power_halve_out(half),
        .supply_range_select_out(vsel), .protocol_select_out(psel),
        .modulator_clock_out_control_out(modc), .irq_mask_out(imask));
    rrm_host_model u_host (.clk_in(clk_in), .host_rdata_in(rdata), .host_rvalid_in(rvalid),
        .host_valid_out(hv), .host_byte_out(hb), .host_frame_out(hf));
    // Latch the code of each command pulse; the pulse lasts one cycle only
    always @(posedge clk_in) if (cmd_p === 1'b1) last_cmd <= cmd_c;
    // Count FIFO strobes; each data port access must give exactly one
    always @(posedge clk_in) if (fwr === 1'b1) n_fwr++;
    always @(posedge clk_in) if (frd === 1'b1) n_frd++;
    // ------------------------------------------------------------
    // Model and checking
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic bit rw(input logic [4:0] a);
        return a <= 5'h0b || a == 5'h0d || (a >= 5'h1a && a <= 5'h1e && a != 5'h1c);
    endfunction
    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        case (a)
            5'h0c: return irq_s;
            5'h0e: return coll_s;
            5'h0f: return lvl_s;
            5'h1c: return fst_s;
            5'h1f: return frd_s;
            default: return mdl[a];
        endcase
    endfunction
    // Write through the host and mirror it; reserved bit 2 never sticks
    task automatic mwr(input logic [4:0] a, input logic [7:0] d, input int n);
        u_host.wr(a, d, n);
        for (int i = 0; i < n; i++) begin
            if (rw(5'(a + i))) mdl[5'(a + i)] = 8'(d + i) & ((5'(a + i) == 5'h00) ? 8'hfb : 8'hff);
        end
    endtask
    task automatic rdchk(input logic [4:0] a);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp_rd(a));
    endtask
    task automatic new_ro();
        @(posedge clk_in);
        {irq_s, coll_s, lvl_s, fst_s} <= $random(seed);
        {frd_s, main_rx, aux_rx} <= 10'($random(seed));
    endtask
    task automatic clear_mdl();
        for (int i = 0; i < 32; i++) mdl[i] = 8'h00;
        mdl[0] = 8'h01;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog well past the wake wait plus all register traffic
    initial begin
        #(5 * 60000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        clear_mdl();
        repeat (5) @(posedge clk_in);
        nrst_in <= 1'b1;
        rdchk(5'h00);
        chk({7'h0, vsel}, 8'h01);
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            new_ro();
            u_host.gap = k;
            for (int a = 0; a < 32; a++) begin
                v = 8'($random(seed));
                mwr(5'(a), v, 1);
                if (a == 31) begin
                    @(negedge clk_in);
                    chk(fwd, v);
                end
                rdchk(5'(a));
            end
            chk(modc, mdl[9]);
            chk(imask, mdl[13]);
        end
        u_host.gap = 0;
        $display("test map done");
        mwr(5'h1d, 8'($random(seed)), 5);
        for (int a = 0; a < 32; a++) rdchk(5'(a));
        $display("test burst done");
        for (int k = 0; k < 24; k++) begin
            v = (k < 8) ? 8'h01 << k : 8'($random(seed));
            new_ro();
            mwr(5'h00, v, 1);
            @(negedge clk_in);
            chk({stby, dmode, tx_on, half, 4'h0}, {v[7:4], 4'h0});
            chk({6'h0, rx_on, osc_on}, {6'h0, {2{v[5] | v[1]}}});
            chk({6'h0, rx_sel, vsel}, {6'h0, v[3] ? aux_rx : main_rx, v[0]});
        end
        mwr(5'h01, 8'h40, 1);
        mwr(5'h00, 8'h41, 1);
        @(negedge clk_in);
        chk({dvar, dmode, 6'h0}, 8'hc0);
        chk(psel, 8'h40);
        $display("test fields done");
        for (int k = 0; k < 4; k++) begin
            v = 8'($random(seed));
            u_host.cmd(v[4:0]);
            repeat (3) @(posedge clk_in);
            chk({3'h0, last_cmd}, {3'h0, v[4:0]});
        end
        $display("test command done");
        @(posedge clk_in);
        chip_enable_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        chip_enable_in <= 1'b1;
        clear_mdl();
        for (int a = 0; a < 12; a++) rdchk(5'(a));
        $display("test enable done");
        mwr(5'h00, 8'h81, 1);
        mwr(5'h00, 8'h01, 1);
        @(negedge clk_in);
        chk({7'h0, rdy}, 8'h00);
        repeat (rrm_pkg::WAKE_CYCLES - 10) @(posedge clk_in);
        chk({7'h0, rdy}, 8'h00);
        repeat (20) @(posedge clk_in);
        chk({7'h0, rdy}, 8'h01);
        $display("test wake done");
        chk(8'(n_fwr), 8'd4);
        chk(8'(n_frd), 8'd4);
        finish_test();
    end
endmodule // reader_register_map_chip_control_tb
`default_nettype wire
